// >>> power_saving_mode_control.sv
// Power-saving mode control: sleep, idle, doze and wake-up sequencing.
//
// Functional notes
// R1 - Pending cases apply with global irq off and a non-clock-switch source pending.
// R2 - Pending irq before sleep makes sleep a no-op; no watchdog clear, no flags.
// R3 - Irq during sleep completes it, wakes, clears watchdog, sets timeout, clears pd.
// R4 - Power-down flag stays set when sleep became a no-op.
// R5 - Crystal oscillator wake waits 1024 oscillator periods; skipped for EC/internal.
// R6 - Irq wake with global irq on vectors to 0x0004, otherwise continues in-line.
// R7 - Sleep enters idle when idle-select is one, full sleep when zero.
// R8 - Idle halts CPU and program memory, keeps all peripheral clocks running.
// R9 - Any enabled irq ends idle even with global irq off; idle-select kept. Here a clock-switch-only irq does not end idle.
// R10 - Recover-on-irq set: ISR entry clears doze-active; clear: unchanged.
// R11 - Doze-on-exit set: ISR return sets doze-active; clear: unchanged.
// R12 - Watchdog timeout in idle wakes instead of reset; doze-active untouched.
// R13 - Only sleep stops Fosc and Fosc/4; other clocks keep running.
// R14 - Three-bit ratio selects 1:2 up to 1:256 as powers of two.
// R15 - Doze runs one CPU cycle per group of N; peripherals full speed.
// R16 - Clock output keeps toggling in idle when its enable option is active.
// R17 - Full sleep entry clears power-down, sets timeout, stops CPU clock.
// R18 - Doze counter restarts whenever doze-active changes.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module power_saving_mode_control
    import power_saving_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Register port
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // CPU core
    input wire logic i_sleep_exec,
    input wire logic i_isr_enter,
    input wire logic i_isr_return,
    input wire logic i_global_irq_enable,
    output logic o_cpu_cycle_en,
    output logic o_vector_to_isr,
    output logic [15:0] o_isr_vector,
    output logic o_resume_inline,
    // Interrupt logic
    input wire logic i_irq_pending,
    input wire logic i_clk_switch_irq_only,
    // Watchdog
    input wire logic i_wdt_timeout,
    output logic o_wdt_clear,
    output logic o_wdt_reset_req,
    // Status flags
    output logic o_timeout_flag_n,
    output logic o_power_down_flag_n,
    // Oscillator and clocks
    input wire logic i_osc_is_crystal,
    input wire logic i_osc_tick,
    input wire logic i_clock_out_enable_n,
    output logic o_fosc_en,
    output logic o_clock_out_en,
    output logic o_in_idle,
    output logic o_in_sleep
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic idle_sel_q;
    logic doze_active_q;
    logic doze_active_d;
    logic roi_q;
    logic doe_q;
    logic [DOZE_RATIO_W-1:0] ratio_q;
    logic [7:0] rdata_q;
    logic timeout_n_q;
    logic timeout_n_d;
    logic pd_n_q;
    logic pd_n_d;
    logic wdt_clear_q;
    logic wdt_clear_d;
    logic vector_q;
    logic vector_d;
    logic inline_q;
    logic inline_d;
    logic wake_by_irq_q;
    logic wake_by_irq_d;
    logic [OSC_STARTUP_W-1:0] ost_cnt_q;
    logic [OSC_STARTUP_W-1:0] ost_cnt_d;
    power_state_e state_q;
    power_state_e state_d;

    // ************************************************************
    // Decode
    // ************************************************************
    logic reg_hit_w;
    logic reg_wr_w;
    logic [7:0] reg_view_w;
    logic wake_irq_w;
    logic doze_restart_w;
    logic doze_cycle_w;

    assign reg_hit_w = (i_reg_addr == DOZE_IDLE_CONTROL_ADDR);
    assign reg_wr_w = i_reg_wr && reg_hit_w;
    assign reg_view_w = {idle_sel_q, doze_active_q, roi_q, doe_q, 1'b0,
                         ratio_q} & DOZE_IDLE_CONTROL_MASK;

    // A pending source that is not the clock-switch interrupt.
    assign wake_irq_w = i_irq_pending && !i_clk_switch_irq_only; // R1

    // ************************************************************
    // Doze-active bit
    // ************************************************************
    // Hardware events win over a software write in the same cycle.
    always_comb begin
        doze_active_d = doze_active_q;
        if (reg_wr_w) begin
            doze_active_d = i_reg_wdata[DOZE_ACTIVE_BIT];
        end
        if (i_isr_enter && roi_q) begin
            doze_active_d = 1'b0; // R10
        end
        if (i_isr_return && doe_q) begin
            doze_active_d = 1'b1; // R11
        end
    end

    assign doze_restart_w = (doze_active_d != doze_active_q); // R18

    doze_divider u_doze_divider (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_doze_on(doze_active_q),
        .i_ratio(ratio_q),
        .i_restart(doze_restart_w),
        .o_cpu_cycle_en(doze_cycle_w)
    );

    // ************************************************************
    // Power state machine
    // ************************************************************
    always_comb begin
        state_d = state_q;
        timeout_n_d = timeout_n_q;
        pd_n_d = pd_n_q;
        wdt_clear_d = 1'b0;
        vector_d = 1'b0;
        inline_d = 1'b0;
        wake_by_irq_d = wake_by_irq_q;
        ost_cnt_d = ost_cnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (i_sleep_exec && wake_irq_w && !i_global_irq_enable) begin
                    // Sleep degrades to a no-op; flags and watchdog kept.
                    state_d = ST_RUN; // R2 R4
                end else if (i_sleep_exec) begin
                    wdt_clear_d = 1'b1;
                    pd_n_d = 1'b0; // R17
                    timeout_n_d = 1'b1; // R17
                    state_d = idle_sel_q ? ST_IDLE : ST_SLEEP; // R7
                end
            end
            ST_IDLE: begin
                // Watchdog timeout wakes rather than resets; not an irq.
                if (wake_irq_w) begin
                    wake_by_irq_d = 1'b1;
                    state_d = ST_WAKE; // R9
                end else if (i_wdt_timeout) begin
                    wake_by_irq_d = 1'b0;
                    state_d = ST_WAKE; // R12
                end
            end
            ST_SLEEP: begin
                if (wake_irq_w || i_wdt_timeout) begin
                    wake_by_irq_d = wake_irq_w;
                    wdt_clear_d = 1'b1; // R3
                    timeout_n_d = wake_irq_w; // R3
                    ost_cnt_d = '0;
                    state_d = i_osc_is_crystal ? ST_OST : ST_WAKE; // R5
                end
            end
            ST_OST: begin
                wdt_clear_d = 1'b1;
                if (i_osc_tick) begin
                    ost_cnt_d = ost_cnt_q + 1'b1;
                    if (ost_cnt_q == OSC_STARTUP_LAST) begin
                        state_d = ST_WAKE; // R5
                    end
                end
            end
            ST_WAKE: begin
                vector_d = wake_by_irq_q && i_global_irq_enable; // R6
                inline_d = !(wake_by_irq_q && i_global_irq_enable); // R6
                state_d = ST_RUN;
            end
        endcase
    end

    // ************************************************************
    // Clock gating and outputs
    // ************************************************************
    logic halted_w;

    assign halted_w = (state_q != ST_RUN);
    assign o_cpu_cycle_en = !halted_w && doze_cycle_w; // R8 R15
    assign o_fosc_en = (state_q != ST_SLEEP) && (state_q != ST_OST); // R13
    assign o_clock_out_en = !i_clock_out_enable_n && o_fosc_en; // R16
    assign o_in_idle = (state_q == ST_IDLE); // R8
    assign o_in_sleep = !o_fosc_en; // R17
    // Watchdog reset only in the run state, not in sleep, start-up, idle or wake.
    assign o_wdt_reset_req = i_wdt_timeout && (state_q == ST_RUN); // R12
    assign o_isr_vector = ISR_VECTOR; // R6
    assign o_reg_rdata = rdata_q;
    assign o_timeout_flag_n = timeout_n_q;
    assign o_power_down_flag_n = pd_n_q;
    assign o_wdt_clear = wdt_clear_q;
    assign o_vector_to_isr = vector_q;
    assign o_resume_inline = inline_q;

    // ************************************************************
    // Flip-flops
    // ************************************************************
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            idle_sel_q <= DOZE_IDLE_CONTROL_RESET[SLEEP_SELECTS_IDLE_BIT];
            roi_q <= DOZE_IDLE_CONTROL_RESET[RECOVER_ON_IRQ_BIT];
            doe_q <= DOZE_IDLE_CONTROL_RESET[DOZE_ON_ISR_EXIT_BIT];
            ratio_q <= DOZE_IDLE_CONTROL_RESET[DOZE_RATIO_W-1:DOZE_RATIO_LSB];
            doze_active_q <= DOZE_IDLE_CONTROL_RESET[DOZE_ACTIVE_BIT];
        end else begin
            // Idle-select is only changed by software.
            if (reg_wr_w) begin
                idle_sel_q <= i_reg_wdata[SLEEP_SELECTS_IDLE_BIT]; // R9
                roi_q <= i_reg_wdata[RECOVER_ON_IRQ_BIT];
                doe_q <= i_reg_wdata[DOZE_ON_ISR_EXIT_BIT];
                ratio_q <= i_reg_wdata[DOZE_RATIO_W-1:DOZE_RATIO_LSB]; // R14
            end
            doze_active_q <= doze_active_d;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= (i_reg_rd && reg_hit_w) ? reg_view_w : '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_RUN;
            timeout_n_q <= 1'b1;
            pd_n_q <= 1'b1;
            wdt_clear_q <= 1'b0;
            vector_q <= 1'b0;
            inline_q <= 1'b0;
            wake_by_irq_q <= 1'b0;
            ost_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            timeout_n_q <= timeout_n_d;
            pd_n_q <= pd_n_d;
            wdt_clear_q <= wdt_clear_d;
            vector_q <= vector_d;
            inline_q <= inline_d;
            wake_by_irq_q <= wake_by_irq_d;
            ost_cnt_q <= ost_cnt_d;
        end
    end

endmodule : power_saving_mode_control

// >>> power_saving_pkg.sv
// Package with register layout, states and timing constants of the power-saving control.
package power_saving_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] DOZE_IDLE_CONTROL_ADDR = 12'h028c;
    localparam logic [7:0] DOZE_IDLE_CONTROL_RESET = 8'h00;
    localparam int SLEEP_SELECTS_IDLE_BIT = 7;
    localparam int DOZE_ACTIVE_BIT = 6;
    localparam int RECOVER_ON_IRQ_BIT = 5;
    localparam int DOZE_ON_ISR_EXIT_BIT = 4;
    localparam int DOZE_RATIO_LSB = 0;
    localparam int DOZE_RATIO_W = 3;
    localparam logic [7:0] DOZE_IDLE_CONTROL_MASK = 8'hf7;

    // ************************************************************
    // Vectors and timing
    // ************************************************************
    localparam logic [15:0] ISR_VECTOR = 16'h0004;
    localparam int OSC_STARTUP_PERIODS = 1024;
    localparam int OSC_STARTUP_W = 11;
    localparam logic [OSC_STARTUP_W-1:0] OSC_STARTUP_LAST =
        OSC_STARTUP_W'(OSC_STARTUP_PERIODS - 1);
    localparam int DOZE_CNT_W = 8;
    localparam logic [DOZE_CNT_W-1:0] DOZE_CNT_ONE = 8'h01;

    // ************************************************************
    // Power states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_SLEEP,
        ST_OST,
        ST_WAKE
    } power_state_e;

endpackage : power_saving_pkg

// >>> doze_divider.sv
// Doze divider that grants one CPU instruction cycle in every group of N.
`timescale 1ns/1ps
module doze_divider
    import power_saving_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_doze_on,
    input wire logic [DOZE_RATIO_W-1:0] i_ratio,
    input wire logic i_restart,
    // Grant
    output logic o_cpu_cycle_en
);

    logic [DOZE_CNT_W-1:0] cnt_q;
    logic [DOZE_CNT_W-1:0] cnt_d;
    logic [DOZE_CNT_W-1:0] last_w;
    logic at_last_w;

    // N is two to the power of code plus one; count runs 0 to N-1.
    // Shift in two steps so code 111 does not wrap the shift amount.
    assign last_w = (DOZE_CNT_ONE << i_ratio << 1) - DOZE_CNT_ONE; // R14
    assign at_last_w = (cnt_q == last_w);
    assign cnt_d = (i_restart || at_last_w) ? '0 : cnt_q + DOZE_CNT_ONE; // R18

    // CPU runs only in the first cycle of each group when doze is on.
    assign o_cpu_cycle_en = !i_doze_on || (cnt_q == '0); // R15

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : doze_divider

// >>> psm_cpu_model.sv
// CPU core model that answers a vector with an ISR and a return.
`timescale 1ns/1ps
module psm_cpu_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // From the block
    input wire logic i_vector_to_isr,
    // To the block
    output logic o_isr_enter,
    output logic o_isr_return,
    output logic o_osc_tick
);
    logic [3:0] isr_cnt_q;
    assign o_osc_tick = 1'b1;
    assign o_isr_enter = (isr_cnt_q == 4'h1);
    assign o_isr_return = (isr_cnt_q == 4'h9);
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            isr_cnt_q <= 4'h0;
        end else if (i_vector_to_isr) begin
            isr_cnt_q <= 4'h1;
        end else if (isr_cnt_q != 4'h0) begin
            isr_cnt_q <= isr_cnt_q + 4'h1;
        end
    end
endmodule : psm_cpu_model

// >>> power_saving_mode_control_chk.sv
// Port checks of the power-saving mode control.
`timescale 1ns/1ps
module power_saving_mode_control_chk (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Inputs
    input wire logic i_sleep_exec,
    input wire logic i_global_irq_enable,
    input wire logic i_irq_pending,
    input wire logic i_clk_switch_irq_only,
    input wire logic i_wdt_timeout,
    input wire logic i_clock_out_enable_n,
    input wire logic i_osc_is_crystal,
    // Outputs
    input wire logic o_cpu_cycle_en,
    input wire logic o_vector_to_isr,
    input wire logic [15:0] o_isr_vector,
    input wire logic o_resume_inline,
    input wire logic o_wdt_clear,
    input wire logic o_wdt_reset_req,
    input wire logic o_timeout_flag_n,
    input wire logic o_power_down_flag_n,
    input wire logic o_fosc_en,
    input wire logic o_clock_out_en,
    input wire logic o_in_idle,
    input wire logic o_in_sleep
);
    wire logic wake_irq;
    assign wake_irq = i_irq_pending && !i_clk_switch_irq_only;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);
    chk_sleep_noop: assert property (
        i_sleep_exec && wake_irq && !i_global_irq_enable && o_fosc_en &&
        !o_in_idle |=> !o_in_sleep && !o_in_idle && !o_wdt_clear &&
        $stable(o_power_down_flag_n) && $stable(o_timeout_flag_n))
        else $error("sleep was not a no-op");
    chk_sleep_entry: assert property ($rose(o_in_sleep) |->
        !o_power_down_flag_n && o_timeout_flag_n && o_wdt_clear)
        else $error("bad sleep entry");
    chk_sleep_gates: assert property (o_in_sleep |->
        !o_fosc_en && !o_cpu_cycle_en) else $error("clock in sleep");
    chk_idle_clocks: assert property (o_in_idle |->
        o_fosc_en && !o_cpu_cycle_en) else $error("bad idle clocks");
    chk_sleep_wake: assert property (
        o_in_sleep && wake_irq && !o_wdt_clear |=>
        (i_osc_is_crystal || !o_in_sleep) && o_wdt_clear &&
        o_timeout_flag_n) else $error("bad wake from sleep");
    chk_idle_wake: assert property (
        o_in_idle && (wake_irq || i_wdt_timeout) |=> !o_in_idle ##1
        (o_vector_to_isr || o_resume_inline)) else $error("idle no wake");
    chk_idle_wdt: assert property (
        o_in_idle && i_wdt_timeout && !wake_irq |=>
        $stable(o_timeout_flag_n) ##1 o_resume_inline && !o_vector_to_isr)
        else $error("bad watchdog wake");
    chk_wdt_no_reset: assert property ((o_in_idle || o_in_sleep) |->
        !o_wdt_reset_req) else $error("reset request while halted");
    chk_vector_addr: assert property (o_vector_to_isr |->
        o_isr_vector == 16'h0004 && !o_resume_inline)
        else $error("bad vector");
    chk_clock_output_pin_idle: assert property (
        o_in_idle && !i_clock_out_enable_n |-> o_clock_out_en)
        else $error("clock out stopped");
endmodule : power_saving_mode_control_chk
bind power_saving_mode_control power_saving_mode_control_chk u_chk (
    .i_sys_clk, .i_arst_n, .i_sleep_exec, .i_global_irq_enable,
    .i_irq_pending, .i_clk_switch_irq_only, .i_wdt_timeout,
    .i_clock_out_enable_n, .i_osc_is_crystal, .o_cpu_cycle_en,
    .o_vector_to_isr,
    .o_isr_vector, .o_resume_inline, .o_wdt_clear, .o_wdt_reset_req,
    .o_timeout_flag_n, .o_power_down_flag_n, .o_fosc_en, .o_clock_out_en,
    .o_in_idle, .o_in_sleep
);

// >>> power_saving_mode_control_test.sv
// Self-checking bench of the power-saving mode control.
`timescale 1ns/1ps
module power_saving_mode_control_test;
    import power_saving_pkg::*;
    logic i_sys_clk, i_arst_n, i_reg_wr, i_reg_rd, i_sleep_exec;
    logic i_isr_enter, i_isr_return, i_global_irq_enable, i_irq_pending;
    logic i_clk_switch_irq_only, i_wdt_timeout, i_osc_is_crystal;
    logic i_osc_tick, i_clock_out_enable_n, o_cpu_cycle_en;
    logic o_vector_to_isr, o_resume_inline, o_wdt_clear, o_wdt_reset_req;
    logic o_timeout_flag_n, o_power_down_flag_n, o_fosc_en, o_clock_out_en;
    logic o_in_idle, o_in_sleep;
    logic [11:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata;
    logic [15:0] o_isr_vector;
    int error_cnt, checks_done, ost, hits, n;
    localparam logic [11:0] REG_A = DOZE_IDLE_CONTROL_ADDR;
    power_saving_mode_control u_power_saving_mode_control (
        .i_sys_clk, .i_arst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .i_sleep_exec, .i_isr_enter, .i_isr_return,
        .i_global_irq_enable, .o_cpu_cycle_en, .o_vector_to_isr,
        .o_isr_vector, .o_resume_inline, .i_irq_pending,
        .i_clk_switch_irq_only, .i_wdt_timeout, .o_wdt_clear,
        .o_wdt_reset_req, .o_timeout_flag_n, .o_power_down_flag_n,
        .i_osc_is_crystal, .i_osc_tick, .i_clock_out_enable_n, .o_fosc_en,
        .o_clock_out_en, .o_in_idle, .o_in_sleep
    );
    psm_cpu_model u_psm_cpu_model (
        .i_sys_clk, .i_arst_n, .i_vector_to_isr(o_vector_to_isr),
        .o_isr_enter(i_isr_enter), .o_isr_return(i_isr_return),
        .o_osc_tick(i_osc_tick)
    );
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        #2;
        check(16'(o_reg_rdata), 16'(e));
    endtask : reg_rd
    task automatic do_sleep();
        @(posedge i_sys_clk);
        i_sleep_exec <= 1'b1;
        @(posedge i_sys_clk);
        i_sleep_exec <= 1'b0;
        #2;
    endtask : do_sleep
    // Waits for the wake pulse and counts start-up cycles on the way.
    task automatic wait_wake();
        ost = 0;
        for (n = 0; n < 2000 && !(o_vector_to_isr || o_resume_inline); n++)
        begin
            @(posedge i_sys_clk);
            #2;
            if (!o_fosc_en && o_wdt_clear) ost++;
        end
        if (n == 2000) begin
            error_cnt++;
            complete_run();
        end
    endtask : wait_wake
    initial begin
        error_cnt = 0;
        checks_done = 0;
        {i_arst_n, i_reg_wr, i_reg_rd, i_sleep_exec, i_irq_pending} = '0;
        {i_global_irq_enable, i_clk_switch_irq_only, i_wdt_timeout} = '0;
        {i_osc_is_crystal, i_clock_out_enable_n} = '0;
        i_reg_addr = 12'h000;
        i_reg_wdata = 8'h00;
        repeat (20) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        reg_rd(REG_A, 8'h00);
        reg_wr(REG_A, 8'hff);
        reg_rd(REG_A, 8'hf7);
        reg_rd(12'h028b, 8'h00);
        reg_wr(REG_A, 8'h00);
        $display("register test done");
        for (int r = 0; r < 8; r++) begin
            reg_wr(REG_A, 8'h40 | 8'(r));
            hits = 0;
            for (int c = 0; c < (4 << r); c++) begin
                #2;
                if (c == 0) check(16'(o_cpu_cycle_en), 16'h0001);
                if (o_cpu_cycle_en === 1'b1) hits++;
                @(posedge i_sys_clk);
            end
            check(16'(hits), 16'h0002);
            reg_wr(REG_A, 8'h00);
        end
        $display("doze test done");
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b1;
        do_sleep();
        check(16'({o_in_sleep, o_power_down_flag_n}), 16'h0001);
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b0;
        do_sleep();
        check(16'({o_in_sleep, o_fosc_en, o_power_down_flag_n,
            o_timeout_flag_n}), 16'h0009);
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b1;
        wait_wake();
        check(16'({o_vector_to_isr, o_resume_inline}), 16'h0001);
        check(16'(ost), 16'h0000);
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b0;
        i_osc_is_crystal <= 1'b1;
        i_global_irq_enable <= 1'b1;
        do_sleep();
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b1;
        wait_wake();
        check(16'({o_vector_to_isr, o_resume_inline}), 16'h0002);
        check(16'(ost), 16'h0400);
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b0;
        i_osc_is_crystal <= 1'b0;
        $display("sleep test done");
        reg_wr(REG_A, 8'he0);
        do_sleep();
        check(16'({o_in_idle, o_fosc_en, o_clock_out_en}), 16'h0007);
        @(posedge i_sys_clk);
        i_wdt_timeout <= 1'b1;
        wait_wake();
        check(16'({o_vector_to_isr, o_resume_inline}), 16'h0001);
        @(posedge i_sys_clk);
        i_wdt_timeout <= 1'b0;
        reg_rd(REG_A, 8'he0);
        reg_wr(REG_A, 8'hf0);
        do_sleep();
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b1;
        wait_wake();
        check(16'({o_vector_to_isr, o_resume_inline}), 16'h0002);
        @(posedge i_sys_clk);
        i_irq_pending <= 1'b0;
        reg_rd(REG_A, 8'hb0);
        repeat (6) @(posedge i_sys_clk);
        reg_rd(REG_A, 8'hf0);
        $display("idle test done");
        complete_run();
    end
endmodule : power_saving_mode_control_test
